// File: sie_debounce.sv
module sie_debounce import sie_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // timebase
   input wire logic tick,
   // line
   input wire logic din,
   input wire logic [15:0] fall_ms,
   input wire logic [15:0] rise_ms,
   output logic q_ff
);

   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic nxt_q;
   logic [15:0] win;

   // ----------------------------------------------------------------
   // level filter, separate windows per direction
   // ----------------------------------------------------------------
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_q = q_ff;
      win = q_ff ? fall_ms : rise_ms;
      if (din == q_ff) begin
         nxt_cnt = 16'h0000;
      end else if (tick) begin
         // window counted in ms ticks (see RULE19)
         nxt_cnt = 16'(cnt_ff + 16'h0001);
         if (nxt_cnt >= win) begin
            nxt_q = din;
            nxt_cnt = 16'h0000;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 16'h0000;
         q_ff <= 1'b0;
      end else if (ce) begin
         cnt_ff <= nxt_cnt;
         q_ff <= nxt_q;
      end
   end

endmodule // sie_debounce

// File: sie_dev_model.sv
module sie_dev_model (
   // command
   input wire logic run,
   input wire logic comp,
   // contact lines
   output logic line_a,
   output logic line_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // complementary device stops with a low and b high
   assign line_a = run;
   assign line_b = comp ? !run : run;
endmodule // sie_dev_model

// File: sie_pkg.sv
package sie_pkg;

   // ----------------------------------------------------------------
   // device classes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SIE_CL_ESTOP   = 4'h0,
      SIE_CL_GATE    = 4'h1,
      SIE_CL_OPTICAL = 4'h2,
      SIE_CL_TWOHAND = 4'h3,
      SIE_CL_ROPE    = 4'h4,
      SIE_CL_PSTOP   = 4'h5,
      SIE_CL_MAT     = 4'h6,
      SIE_CL_ENABLE  = 4'h7,
      SIE_CL_MUTE    = 4'h8,
      SIE_CL_BYPASS  = 4'h9,
      SIE_CL_EDM     = 4'hA,
      SIE_CL_VALVE   = 4'hB
   } sie_class_t;

   // ----------------------------------------------------------------
   // lockout states
   // ----------------------------------------------------------------
   typedef enum logic {
      SIE_ST_RUN  = 1'b0,
      SIE_ST_LOCK = 1'b1
   } sie_state_t;

   // ----------------------------------------------------------------
   // circuit type counts per class
   // ----------------------------------------------------------------
   localparam logic [3:0] SIE_CT_ESTOP = 4'h7;
   localparam logic [3:0] SIE_CT_GATE = 4'hD;
   localparam logic [3:0] SIE_CT_TEN = 4'hA;
   localparam logic [3:0] SIE_CT_SEVEN = 4'h7;
   localparam logic [3:0] SIE_CT_MAT = 4'h1;
   localparam logic [3:0] SIE_CT_TWO = 4'h2;

   // circuit type field positions
   localparam int SIE_CT_COMP_BIT = 0;
   localparam int SIE_CT_DUAL_BIT = 1;

   // ----------------------------------------------------------------
   // debounce limits, ms
   // ----------------------------------------------------------------
   localparam logic [15:0] SIE_FALL_MIN_MS = 16'h0006;
   localparam logic [15:0] SIE_FALL_MAX_MS = 16'h0064;
   localparam logic [15:0] SIE_FALL_DEF_MS = 16'h0006;
   localparam logic [15:0] SIE_RISE_MIN_MS = 16'h000A;
   localparam logic [15:0] SIE_RISE_MAX_MS = 16'h01F4;
   localparam logic [15:0] SIE_RISE_DEF_MS = 16'h0032;
   localparam logic [15:0] SIE_MUTE_MAX_MS = 16'h05DC;

   // ----------------------------------------------------------------
   // timebase
   // ----------------------------------------------------------------
   localparam int SIE_CLK_PERIOD_NS = 4;
   localparam int SIE_MS_NS = 1000000;
   localparam int SIE_CYC_PER_MS = SIE_MS_NS / SIE_CLK_PERIOD_NS;
   localparam logic [15:0] SIE_SIM_WIN_MS = 16'h0064;
   localparam logic [15:0] SIE_CONC_WIN_MS = 16'h01F4;

   // ----------------------------------------------------------------
   // class properties
   // ----------------------------------------------------------------
   function automatic logic [3:0] sie_ct_count(input logic [3:0] cl);
      case (cl)
         SIE_CL_ESTOP: sie_ct_count = SIE_CT_ESTOP;
         SIE_CL_GATE: sie_ct_count = SIE_CT_GATE;
         SIE_CL_OPTICAL, SIE_CL_ROPE, SIE_CL_PSTOP, SIE_CL_ENABLE,
         SIE_CL_BYPASS: sie_ct_count = SIE_CT_TEN;
         SIE_CL_TWOHAND, SIE_CL_MUTE: sie_ct_count = SIE_CT_SEVEN;
         SIE_CL_MAT: sie_ct_count = SIE_CT_MAT;
         SIE_CL_EDM, SIE_CL_VALVE: sie_ct_count = SIE_CT_TWO;
         default: sie_ct_count = 4'h0;
      endcase
   endfunction

   function automatic logic sie_auto_only(input logic [3:0] cl);
      sie_auto_only = (cl == SIE_CL_TWOHAND) || (cl == SIE_CL_ENABLE) ||
                      (cl == SIE_CL_MUTE) || (cl == SIE_CL_BYPASS) ||
                      (cl == SIE_CL_EDM) || (cl == SIE_CL_VALVE);
   endfunction

   function automatic logic sie_can_mute(input logic [3:0] cl);
      sie_can_mute = (cl == SIE_CL_GATE) || (cl == SIE_CL_OPTICAL) ||
                     (cl == SIE_CL_TWOHAND) || (cl == SIE_CL_PSTOP) ||
                     (cl == SIE_CL_MAT);
   endfunction

   function automatic logic sie_has_tlim(input logic [3:0] cl);
      sie_has_tlim = (cl == SIE_CL_ENABLE) || (cl == SIE_CL_MUTE) ||
                     (cl == SIE_CL_BYPASS) || (cl == SIE_CL_VALVE);
   endfunction

   function automatic logic sie_has_sut(input logic [3:0] cl);
      sie_has_sut = (cl == SIE_CL_GATE) || (cl == SIE_CL_OPTICAL);
   endfunction

endpackage

// File: sie_tb.sv
module testbench import sie_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NI = 4;
   localparam int NO = 2;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic mrst_in = 1'b0;
   logic srst_in = 1'b0;
   logic [3:0] run = 4'h0;
   logic [3:0] man = 4'h2, simul = 4'hF, alow = 4'h0, sut = 4'h2;
   logic [3:0] mut = 4'h2, byp = 4'h0;
   wire [7:0] term;
   logic [3:0] cls [NI];
   logic [3:0] ct [NI];
   logic [2:0] ta [NI];
   logic [2:0] tb [NI];
   logic [NO-1:0] omap [NI];
   logic [NI-1:0] imap [NI];
   logic [15:0] fall [NI];
   logic [15:0] rise [NI];
   logic [15:0] tlim [NI];
   logic [NO-1:0] sout, sout_d;
   logic [NI-1:0] irun, ifault, ilatch, irun_d, ifault_d, ilatch_d;
   logic lock, lock_d;
   int mismatches = 0;
   int num_checks = 0;

   always #2 core_clk = ~core_clk;

   // ------------------------------------------------------------
   // devices and design
   // ------------------------------------------------------------
   // in0 estop pair, in1 gate complementary latch, in2 mute, in3 single
   for (genvar g = 0; g < NI; g++) begin : g_dev
      sie_dev_model m (.run(run[g]), .comp(g == 1),
         .line_a(term[2*g]), .line_b(term[2*g+1]));
   end

   sie_top #(.TICK_CYC(4)) dut (
      .core_clk(core_clk), .rstn(rstn), .ce(ce), .term_in(term),
      .manual_reset_in(mrst_in), .system_reset_in(srst_in),
      .cfg_class(cls), .cfg_circuit(ct), .cfg_term_a(ta), .cfg_term_b(tb),
      .cfg_manual(man), .cfg_out_map(omap), .cfg_in_map(imap),
      .cfg_cos_simul(simul), .cfg_active_low(alow), .cfg_fall_ms(fall),
      .cfg_rise_ms(rise), .cfg_startup_test(sut),
      .cfg_time_limit_ms(tlim), .cfg_mutable(mut), .cfg_bypassable(byp),
      .safety_out_ff(sout_d), .input_run_ff(irun_d),
      .input_fault_ff(ifault_d), .input_latched_ff(ilatch_d),
      .lockout_ff(lock_d));

   // compare against copies taken at the falling edge, when settled
   always @(negedge core_clk) begin
      {sout, irun, ifault, ilatch} <= {sout_d, irun_d, ifault_d, ilatch_d};
      lock <= lock_d;
   end

   initial begin
      for (int i = 0; i < NI; i++) begin
         fall[i] = 16'h0006;
         rise[i] = 16'h000A;
         tlim[i] = 16'h00C8;
         imap[i] = 4'h0;
         ta[i] = 3'(2 * i);
         tb[i] = 3'(2 * i + 1);
      end
      cls = '{SIE_CL_ESTOP, SIE_CL_GATE, SIE_CL_MUTE, SIE_CL_PSTOP};
      ct = '{4'h2, 4'h3, 4'h2, 4'h0};
      omap = '{2'h1, 2'h2, 2'h0, 2'h1};
      imap[2] = 4'h2;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic chk(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask

   // pulses span two sync stages plus margin
   task automatic pulse_s();
      srst_in <= 1'b1;
      cyc(8);
      srst_in <= 1'b0;
      cyc(8);
   endtask

   task automatic pulse_m();
      mrst_in <= 1'b1;
      cyc(8);
      mrst_in <= 1'b0;
      cyc(8);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(lock, 1'b1, "no lockout after reset");
      chk(sout[0] | sout[1], 1'b0, "output on after reset");
      ce <= 1'b0;
      pulse_s();
      chk(lock, 1'b1, "lockout left while frozen");
      ce <= 1'b1;
      pulse_s();
      chk(lock, 1'b0, "lockout kept");
      $display("test reset done");
   endtask

   // debounce of 10 ticks is 40 cycles, stop of 6 ticks is 24
   task automatic t_pair();
      run[0] <= 1'b1;
      run[3] <= 1'b1;
      cyc(30);
      chk(irun[0], 1'b0, "run before debounce");
      cyc(30);
      chk(irun[0], 1'b1, "equal pair not run");
      chk(sout[0], 1'b1, "output off with all run");
      run[3] <= 1'b0;
      cyc(40);
      chk(sout[0], 1'b0, "output on with a stop");
      run[3] <= 1'b1;
      cyc(60);
      chk(sout[0], 1'b1, "trip input held output");
      alow[3] <= 1'b1;
      cyc(4);
      chk(irun[3], 1'b0, "low convention ignored");
      alow[3] <= 1'b0;
      cyc(4);
      $display("test pair done");
   endtask

   task automatic t_latch();
      run[1] <= 1'b1;
      cyc(60);
      chk(irun[1], 1'b1, "complementary pair not run");
      pulse_m();
      chk(sout[1], 1'b1, "tested gate kept off");
      run[1] <= 1'b0;
      cyc(40);
      chk(sout[1], 1'b0, "gate stop ignored");
      run[1] <= 1'b1;
      cyc(60);
      chk(ilatch[1], 1'b1, "latch not held");
      chk(sout[1], 1'b0, "latched output on");
      pulse_m();
      chk(sout[1], 1'b1, "manual reset ignored");
      $display("test latch done");
   endtask

   task automatic t_mute();
      run[2] <= 1'b1;
      cyc(60);
      run[1] <= 1'b0;
      cyc(40);
      chk(irun[1], 1'b0, "gate still run");
      chk(sout[1], 1'b1, "muted stop not ignored");
      run[2] <= 1'b0;
      cyc(40);
      chk(sout[1], 1'b0, "stop ignored without mute");
      run[1] <= 1'b1;
      cyc(60);
      $display("test mute done");
   endtask

   task automatic t_badct();
      ct[0] <= 4'h7;
      cyc(6);
      chk(ifault[0], 1'b1, "bad circuit type accepted");
      chk(lock, 1'b1, "no lockout on fault");
      chk(sout[0], 1'b0, "output on in lockout");
      ct[0] <= 4'h2;
      cyc(6);
      chk(lock, 1'b1, "lockout left without reset");
      pulse_s();
      chk(lock, 1'b0, "lockout not cleared");
      $display("test circuit type done");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      cyc(4);
      rstn <= 1'b1;
      cyc(4);
      t_reset();
      t_pair();
      t_latch();
      t_mute();
      t_badct();
      test_done();
   end

   // the tests need about 630 cycles
   initial begin
      cyc(20000);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end
endmodule // testbench

bind sie_top sie_top_props #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_props (
   .core_clk(core_clk), .rstn(rstn), .system_reset_in(system_reset_in),
   .cfg_class(cfg_class), .cfg_circuit(cfg_circuit),
   .cfg_manual(cfg_manual), .cfg_out_map(cfg_out_map),
   .cfg_mutable(cfg_mutable), .cfg_bypassable(cfg_bypassable),
   .safety_out_ff(safety_out_ff), .input_run_ff(input_run_ff),
   .input_fault_ff(input_fault_ff), .input_latched_ff(input_latched_ff),
   .lockout_ff(lockout_ff));

// File: sie_top.sv
// Function
// (RULE1) output On only when all mapped inputs run
// (RULE2) active mute or bypass ignores stop
// (RULE3) fault locks out until cleared
// (RULE4) equal-polarity pair: both high is run
// (RULE5) complementary pair: high and low is run
// (RULE6) circuit type per class, range checked
// (RULE7) trip or latch; some classes trip only
// (RULE8) per-input map to outputs and inputs
// (RULE9) simultaneous or concurrent, high or low
// (RULE10) start-up test after power-up for gate/optical
// (RULE11) time limit on timed functions
// (RULE12) mute only with mutable flag
// (RULE13) bypass only with bypassable flag
// (RULE14) inputs taken from assigned terminals
// (RULE15) stop debounce 6..100 ms, mute 1500
// (RULE16) run debounce 10..500 ms, mute 1500
// (RULE17) any mapped stop turns output off
// (RULE18) latch waits manual reset, trip releases
// (RULE19) debounce on 1 ms tick
// (RULE20) lockout forces all outputs off
module sie_top import sie_pkg::*; #(
   parameter int NUM_IN = 4,
   parameter int NUM_OUT = 2,
   parameter int NUM_TERM = 8,
   parameter int TERM_W = 3,
   parameter int TICK_CYC = SIE_CYC_PER_MS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   // terminal pins
   input wire logic [NUM_TERM-1:0] term_in,
   input wire logic manual_reset_in,
   input wire logic system_reset_in,
   // per-input configuration
   input wire logic [3:0] cfg_class [NUM_IN],
   input wire logic [3:0] cfg_circuit [NUM_IN],
   input wire logic [TERM_W-1:0] cfg_term_a [NUM_IN],
   input wire logic [TERM_W-1:0] cfg_term_b [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_manual,
   input wire logic [NUM_OUT-1:0] cfg_out_map [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_in_map [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_cos_simul,
   input wire logic [NUM_IN-1:0] cfg_active_low,
   input wire logic [15:0] cfg_fall_ms [NUM_IN],
   input wire logic [15:0] cfg_rise_ms [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_startup_test,
   input wire logic [15:0] cfg_time_limit_ms [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_mutable,
   input wire logic [NUM_IN-1:0] cfg_bypassable,
   // status
   output logic [NUM_OUT-1:0] safety_out_ff,
   output logic [NUM_IN-1:0] input_run_ff,
   output logic [NUM_IN-1:0] input_fault_ff,
   output logic [NUM_IN-1:0] input_latched_ff,
   output logic lockout_ff
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [NUM_TERM+1:0] sync1_ff;
   logic [NUM_TERM+1:0] sync2_ff;
   logic mreset_prev_ff;
   logic [NUM_TERM-1:0] term_s;
   logic mreset_s;
   logic sreset_s;
   logic mreset_pulse;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         mreset_prev_ff <= 1'b0;
      end else if (ce) begin
         sync1_ff <= {system_reset_in, manual_reset_in, term_in};
         sync2_ff <= sync1_ff;
         mreset_prev_ff <= mreset_s;
      end
   end

   assign term_s = sync2_ff[NUM_TERM-1:0];
   assign mreset_s = sync2_ff[NUM_TERM];
   assign sreset_s = sync2_ff[NUM_TERM+1];
   assign mreset_pulse = mreset_s & ~mreset_prev_ff;

   // ----------------------------------------------------------------
   // 1 ms timebase
   // ----------------------------------------------------------------
   logic [31:0] tick_cnt_ff;
   logic [31:0] nxt_tick_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb begin
      nxt_tick = 1'b0;
      nxt_tick_cnt = 32'(tick_cnt_ff + 32'h00000001);
      if (tick_cnt_ff == 32'(TICK_CYC - 1)) begin
         nxt_tick_cnt = 32'h00000000;
         nxt_tick = 1'b1; // see (RULE19)
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_ff <= 32'h00000000;
         tick_ff <= 1'b0;
      end else if (ce) begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // ----------------------------------------------------------------
   // per-input evaluation
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] run_w;
   logic [NUM_IN-1:0] ok_w;
   logic [NUM_IN-1:0] fault_w;
   logic [NUM_IN-1:0] latched_w;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_in
         logic deb_a;
         logic deb_b;
         logic [15:0] fall_eff;
         logic [15:0] rise_eff;
         logic [15:0] dmax_fall;
         logic [15:0] dmax_rise;
         logic is_mute_cl;
         logic run_a;
         logic run_b;
         logic dual;
         logic run_raw;
         logic mismatch;
         logic cfg_bad;
         logic manual_eff;
         logic muted;
         logic bypassed;
         logic ignore;
         logic sut_need;
         logic [15:0] disp_cnt_ff;
         logic [15:0] nxt_disp_cnt;
         logic [15:0] func_cnt_ff;
         logic [15:0] nxt_func_cnt;
         logic disp_err_ff;
         logic nxt_disp_err;
         logic func_err_ff;
         logic nxt_func_err;
         logic latched_ff;
         logic nxt_latched;
         logic saw_stop_ff;
         logic nxt_saw_stop;
         logic tested_ff;
         logic nxt_tested;
         logic [15:0] cos_win;

         // debounce windows clamped to class limits
         always_comb begin
            is_mute_cl = (cfg_class[gi] == SIE_CL_MUTE);
            dmax_fall = is_mute_cl ? SIE_MUTE_MAX_MS : SIE_FALL_MAX_MS;
            dmax_rise = is_mute_cl ? SIE_MUTE_MAX_MS : SIE_RISE_MAX_MS;
            fall_eff = cfg_fall_ms[gi]; // see (RULE15)
            if (fall_eff < SIE_FALL_MIN_MS) begin
               fall_eff = SIE_FALL_MIN_MS;
            end else if (fall_eff > dmax_fall) begin
               fall_eff = dmax_fall;
            end
            rise_eff = cfg_rise_ms[gi]; // see (RULE16)
            if (rise_eff < SIE_RISE_MIN_MS) begin
               rise_eff = SIE_RISE_MIN_MS;
            end else if (rise_eff > dmax_rise) begin
               rise_eff = dmax_rise;
            end
         end

         // lines picked from assigned terminals (see RULE14)
         sie_debounce u_deb_a (
            .core_clk(core_clk),
            .rstn(rstn),
            .ce(ce),
            .tick(tick_ff),
            .din(term_s[cfg_term_a[gi]]),
            .fall_ms(fall_eff),
            .rise_ms(rise_eff),
            .q_ff(deb_a)
         );

         sie_debounce u_deb_b (
            .core_clk(core_clk),
            .rstn(rstn),
            .ce(ce),
            .tick(tick_ff),
            .din(term_s[cfg_term_b[gi]]),
            .fall_ms(fall_eff),
            .rise_ms(rise_eff),
            .q_ff(deb_b)
         );

         always_comb begin
            dual = cfg_circuit[gi][SIE_CT_DUAL_BIT];
            // active-low convention inverts both lines (see RULE9)
            run_a = deb_a ^ cfg_active_low[gi];
            // complementary pair wants b opposite to a (see RULE5)
            run_b = (deb_b ^ cfg_circuit[gi][SIE_CT_COMP_BIT]) ^
                    cfg_active_low[gi];
            // equal pair wants both high (see RULE4)
            run_raw = dual ? (run_a & run_b) : run_a;
            mismatch = dual & (run_a ^ run_b);
            // out-of-range circuit type is a fault (see RULE6)
            cfg_bad = (cfg_circuit[gi] >= sie_ct_count(cfg_class[gi]));
            // latch refused for trip-only classes (see RULE7)
            manual_eff = cfg_manual[gi] & ~sie_auto_only(cfg_class[gi]);
            sut_need = cfg_startup_test[gi] & sie_has_sut(cfg_class[gi]);
            cos_win = cfg_cos_simul[gi] ? SIE_SIM_WIN_MS : SIE_CONC_WIN_MS;
            // mute/bypass sources reach inputs via input map (see RULE8)
            muted = 1'b0;
            bypassed = 1'b0;
            for (int j = 0; j < NUM_IN; j++) begin
               if (cfg_in_map[j][gi] && run_w[j]) begin
                  if (cfg_class[j] == SIE_CL_MUTE) begin
                     muted = 1'b1;
                  end
                  if (cfg_class[j] == SIE_CL_BYPASS) begin
                     bypassed = 1'b1;
                  end
               end
            end
            // mute needs mutable flag (see RULE12)
            // bypass needs bypassable flag (see RULE13)
            ignore = (muted & cfg_mutable[gi] &
                      sie_can_mute(cfg_class[gi])) |
                     (bypassed & cfg_bypassable[gi] &
                      sie_can_mute(cfg_class[gi]));
         end

         // pair disparity and function time limit
         always_comb begin
            nxt_disp_cnt = disp_cnt_ff;
            nxt_disp_err = disp_err_ff;
            nxt_func_cnt = func_cnt_ff;
            nxt_func_err = func_err_ff;
            if (!mismatch) begin
               nxt_disp_cnt = 16'h0000;
            end else if (tick_ff && disp_cnt_ff != 16'hFFFF) begin
               nxt_disp_cnt = 16'(disp_cnt_ff + 16'h0001);
            end
            if (nxt_disp_cnt > cos_win) begin
               nxt_disp_err = 1'b1; // see (RULE9)
            end
            if (!(run_raw && sie_has_tlim(cfg_class[gi]))) begin
               nxt_func_cnt = 16'h0000;
            end else if (tick_ff && func_cnt_ff != 16'hFFFF) begin
               nxt_func_cnt = 16'(func_cnt_ff + 16'h0001);
            end
            if (nxt_func_cnt > cfg_time_limit_ms[gi]) begin
               nxt_func_err = 1'b1; // see (RULE11)
            end
            // errors clear only with system reset once the cause is gone
            if (sreset_s && !mismatch && nxt_func_cnt == 16'h0000) begin
               nxt_disp_err = 1'b0;
               nxt_func_err = 1'b0;
            end
         end

         // latch and start-up test
         always_comb begin
            nxt_latched = latched_ff;
            nxt_saw_stop = saw_stop_ff | ~run_raw;
            nxt_tested = tested_ff | (saw_stop_ff & run_raw); // see (RULE10)
            if (mreset_pulse && run_raw) begin
               nxt_latched = 1'b0; // see (RULE18)
            end
            // a stop during the reset cycle still latches
            if (manual_eff && !run_raw && !ignore) begin
               nxt_latched = 1'b1; // see (RULE18)
            end
            if (!manual_eff) begin
               nxt_latched = 1'b0;
            end
         end

         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               disp_cnt_ff <= 16'h0000;
               func_cnt_ff <= 16'h0000;
               disp_err_ff <= 1'b0;
               func_err_ff <= 1'b0;
               latched_ff <= 1'b0;
               saw_stop_ff <= 1'b0;
               tested_ff <= 1'b0;
            end else if (ce) begin
               disp_cnt_ff <= nxt_disp_cnt;
               func_cnt_ff <= nxt_func_cnt;
               disp_err_ff <= nxt_disp_err;
               func_err_ff <= nxt_func_err;
               latched_ff <= nxt_latched;
               saw_stop_ff <= nxt_saw_stop;
               tested_ff <= nxt_tested;
            end
         end

         assign run_w[gi] = run_raw;
         assign latched_w[gi] = latched_ff;
         assign fault_w[gi] = cfg_bad | disp_err_ff | func_err_ff;
         // ignored stop keeps output on (see RULE2)
         assign ok_w[gi] = ((run_raw & ~latched_ff) | ignore) &
                           (tested_ff | ~sut_need);
      end
   endgenerate

   // ----------------------------------------------------------------
   // lockout and outputs
   // ----------------------------------------------------------------
   sie_state_t state_ff;
   sie_state_t nxt_state;
   logic [NUM_OUT-1:0] nxt_out;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SIE_ST_RUN: begin
            if (|fault_w) begin
               nxt_state = SIE_ST_LOCK; // see (RULE3)
            end
         end
         SIE_ST_LOCK: begin
            // fault must be gone and system reset given
            if (!(|fault_w) && sreset_s) begin
               nxt_state = SIE_ST_RUN; // see (RULE3)
            end
         end
         default: nxt_state = SIE_ST_LOCK;
      endcase
      for (int o = 0; o < NUM_OUT; o++) begin
         // and of all mapped inputs (see RULE1) (see RULE17)
         nxt_out[o] = 1'b1;
         for (int i = 0; i < NUM_IN; i++) begin
            if (cfg_out_map[i][o] && !ok_w[i]) begin
               nxt_out[o] = 1'b0;
            end
         end
      end
      if (nxt_state == SIE_ST_LOCK) begin
         nxt_out = '0; // see (RULE20)
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= SIE_ST_LOCK;
         safety_out_ff <= '0;
         input_run_ff <= '0;
         input_fault_ff <= '0;
         input_latched_ff <= '0;
         lockout_ff <= 1'b1;
      end else if (ce) begin
         state_ff <= nxt_state;
         safety_out_ff <= nxt_out;
         input_run_ff <= run_w;
         input_fault_ff <= fault_w;
         input_latched_ff <= latched_w;
         lockout_ff <= (nxt_state == SIE_ST_LOCK);
      end
   end

endmodule // sie_top

// File: sie_top_props.sv
module sie_top_props import sie_pkg::*; #(
   parameter int NUM_IN = 4,
   parameter int NUM_OUT = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // pins and configuration
   input wire logic system_reset_in,
   input wire logic [3:0] cfg_class [NUM_IN],
   input wire logic [3:0] cfg_circuit [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_manual,
   input wire logic [NUM_OUT-1:0] cfg_out_map [NUM_IN],
   input wire logic [NUM_IN-1:0] cfg_mutable,
   input wire logic [NUM_IN-1:0] cfg_bypassable,
   // status
   input wire logic [NUM_OUT-1:0] safety_out_ff,
   input wire logic [NUM_IN-1:0] input_run_ff,
   input wire logic [NUM_IN-1:0] input_fault_ff,
   input wire logic [NUM_IN-1:0] input_latched_ff,
   input wire logic lockout_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // ------------------------------------------------------------
   // outputs that an unignorable stop or a latch must hold off
   // ------------------------------------------------------------
   // mutable or bypassable inputs left out: their stop may be masked
   logic [NUM_OUT-1:0] blocked;
   always_comb begin
      blocked = '0;
      for (int o = 0; o < NUM_OUT; o++) begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (cfg_out_map[i][o] && (input_latched_ff[i] ||
                (!input_run_ff[i] && !cfg_mutable[i] && !cfg_bypassable[i])))
            begin
               blocked[o] = 1'b1;
            end
         end
      end
   end

   a_lock_out_off: assert property (
      lockout_ff |-> safety_out_ff == '0)
      else $error("output on during lockout");
   a_stop_out_off: assert property (
      (blocked & safety_out_ff) == '0)
      else $error("output on while a mapped input stops");
   a_lock_holds: assert property (
      input_fault_ff != '0 |-> lockout_ff)
      else $error("lockout left with fault present");
   a_no_exit: assert property (
      (lockout_ff && !system_reset_in) [*5] |=> lockout_ff)
      else $error("lockout left without system reset");
   a_start_stop: assert property (
      $rose(rstn) |-> (input_run_ff == '0) [*8])
      else $error("input run too soon after reset");

   for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      a_fault_locks: assert property (
         input_fault_ff[i] |-> ##[0:2] lockout_ff)
         else $error("fault without lockout");
      a_bad_type: assert property (
         cfg_class[i] == SIE_CL_ESTOP && cfg_circuit[i] > 4'h6
         |-> ##[0:3] input_fault_ff[i])
         else $error("bad circuit type accepted");
      a_trip_no_latch: assert property (
         !cfg_manual[i] || cfg_class[i] inside {SIE_CL_TWOHAND,
         SIE_CL_ENABLE, SIE_CL_MUTE, SIE_CL_BYPASS}
         |-> !input_latched_ff[i])
         else $error("trip input latched");
   end
endmodule // sie_top_props
